/* File: sim/iqr_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module iqr_core_model (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Vectoring outputs of the block.
  input  wire logic core_vector,
  input  wire logic core_wake,
  // Sleep instruction request from the bench.
  input  wire logic sleep_req,
  output logic      core_sleep_enter,
  // Event counts and cycle stamps.
  output int        n_vec,
  output int        n_wake,
  output int        vec_cyc,
  output int        wake_cyc
);
  // ****************************************************************
  // Core side: executes sleep, counts wakes and vector branches.
  // ****************************************************************
  int cyc;

  // Stamps let the bench see that one instruction runs between wake and vector.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc              <= 0;
      core_sleep_enter <= 1'b0;
      n_vec            <= 0;
      n_wake           <= 0;
      vec_cyc          <= 0;
      wake_cyc         <= 0;
    end else begin
      cyc              <= cyc + 1;
      core_sleep_enter <= sleep_req;
      if (core_wake) begin
        n_wake   <= n_wake + 1;
        wake_cyc <= cyc;
      end
      if (core_vector) begin
        n_vec   <= n_vec + 1;
        vec_cyc <= cyc;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest, ext_pin;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, capture_evt, per_evt;
  logic        sleep_req, core_sleep_enter, core_irq_request, core_vector;
  logic        core_wake, core_asleep;
  logic [7:0]  rd, v;
  int          n_vec, n_wake, vec_cyc, wake_cyc, n_mismatch, checks, seed, lat, i, nv;

  iqr_ctrl #(.DISPATCH_Q1S(iqr_pkg::DISPATCH_Q1S)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_pin(ext_pin),
    .osc_fail_evt(per_evt[3]), .clk_switch_evt(per_evt[2]),
    .adc_thresh_evt(per_evt[1]), .adc_done_evt(per_evt[0]), .capture_evt(capture_evt),
    .core_sleep_enter(core_sleep_enter), .core_irq_request(core_irq_request),
    .core_vector(core_vector), .core_wake(core_wake), .core_asleep(core_asleep));

  iqr_core_model i_core (
    .core_clk(core_clk), .rst_n(rst_n), .core_vector(core_vector), .core_wake(core_wake),
    .sleep_req(sleep_req), .core_sleep_enter(core_sleep_enter), .n_vec(n_vec),
    .n_wake(n_wake), .vec_cyc(vec_cyc), .wake_cyc(wake_cyc));

  always #4 core_clk = ~core_clk;

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // Pin flag expected after an edge, from the selected direction and the new level.
  function automatic logic [7:0] exp_pin_flag(input logic rising, input logic lvl);
    return (lvl == rising) ? iqr_pkg::PIN_MASK : 8'h00;
  endfunction

  // The request is held until waitrequest is seen low, then dropped for one edge.
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
                     input logic be);
    int n;
    n = 0;
    avs_address    <= {idx, 2'b00};
    avs_read       <= ~w;
    avs_write      <= w;
    avs_writedata  <= {24'h0000_00, d};
    avs_byteenable <= {3'h0, be};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) check(32'h0, 32'h1, "bus hang");
    rd = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b1);
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [7:0] e, input string m);
    bus(1'b0, idx, 8'h00, 1'b1);
    check({24'h0000_00, rd}, {24'h0000_00, e}, m);
  endtask

  task automatic evt(input logic [3:0] s);
    per_evt <= s;
    @(posedge core_clk);
    per_evt <= 4'h0;
  endtask

  // Counts edges from the request rising to the vector pulse.
  task automatic meas(output int c);
    int n;
    n = 0;
    c = 0;
    while (core_irq_request !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    while (core_vector !== 1'b1 && c < 60) begin
      @(posedge core_clk);
      c++;
    end
  endtask

  task automatic wait_cnt(ref int cnt, input int old);
    int n;
    n = 0;
    while (cnt == old && n < 80) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog; the whole run needs well under a thousand cycles.
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {avs_read, avs_write, ext_pin, sleep_req} = 4'h0;
    avs_address = 14'h0000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    capture_evt = 4'h0;
    per_evt = 4'h0;
    n_mismatch = 0;
    checks = 0;
    seed = 31650;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdchk(iqr_pkg::IDX_EN_CAP, 8'h00, "capture enable reset");
    rdchk(iqr_pkg::IDX_FLAGS_CLK, 8'h00, "clock flags reset");
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(iqr_pkg::IDX_EN_CAP, v);
      rdchk(iqr_pkg::IDX_EN_CAP, v & 8'h0F, "capture enable");
      capture_evt <= $random(seed);
      @(posedge core_clk);
      nv = capture_evt;
      capture_evt <= 4'h0;
      rdchk(iqr_pkg::IDX_FLAGS_CAP, nv[7:0], "capture flags");
      wr(iqr_pkg::IDX_FLAGS_CAP, 8'h00);
    end
    bus(1'b1, iqr_pkg::IDX_EN_CAP, ~v, 1'b0);
    rdchk(iqr_pkg::IDX_EN_CAP, v & 8'h0F, "write without byte lane");
    rdchk(12'h0001, 8'h00, "unmapped read");
    $display("test registers done");
    evt(4'hF);
    rdchk(iqr_pkg::IDX_FLAGS_CLK, 8'hC3, "flags with enables off");
    check({31'h0, core_irq_request}, 32'h0, "request without enables");
    repeat (20) @(posedge core_clk);
    rdchk(iqr_pkg::IDX_FLAGS_CLK, 8'hC3, "flags sticky");
    wr(iqr_pkg::IDX_FLAGS_CLK, 8'h00);
    rdchk(iqr_pkg::IDX_FLAGS_CLK, 8'h00, "flags cleared by write");
    wr(iqr_pkg::IDX_EN_CLK, 8'h01);
    wr(iqr_pkg::IDX_CORE_CTRL, 8'h80);
    evt(4'h1);
    repeat (8) @(posedge core_clk);
    check({31'h0, core_irq_request}, 32'h0, "peripheral without group enable");
    rdchk(iqr_pkg::IDX_FLAGS_CLK, 8'h01, "adc done flag");
    wr(iqr_pkg::IDX_FLAGS_CLK, 8'h00);
    wr(iqr_pkg::IDX_CORE_CTRL, 8'hC0);
    evt(4'h1);
    meas(lat);
    check({31'h0, lat >= 12 && lat <= 16}, 32'h1, "sync latency");
    rdchk(iqr_pkg::IDX_CORE_CTRL, 8'h40, "global enable after vector");
    wr(iqr_pkg::IDX_FLAGS_CLK, 8'h00);
    $display("test peripheral done");
    for (i = 0; i < 4; i++) begin
      wr(iqr_pkg::IDX_CORE_CTRL, (i < 2) ? 8'h01 : 8'h00);
      wr(iqr_pkg::IDX_FLAGS_PIN, 8'h00);
      ext_pin <= ~ext_pin;
      repeat (12) @(posedge core_clk);
      rdchk(iqr_pkg::IDX_FLAGS_PIN, exp_pin_flag(i < 2, ext_pin), "pin edge");
    end
    wr(iqr_pkg::IDX_CORE_CTRL, 8'h80);
    repeat (8) @(posedge core_clk);
    check({31'h0, core_irq_request}, 32'h0, "pin flag without enable");
    wr(iqr_pkg::IDX_CORE_CTRL, 8'h01);
    wr(iqr_pkg::IDX_FLAGS_PIN, 8'h00);
    wr(iqr_pkg::IDX_EN_BANK0, 8'h10);
    wr(iqr_pkg::IDX_CORE_CTRL, 8'h81);
    ext_pin <= 1'b1;
    meas(lat);
    check({31'h0, lat >= 12 && lat <= 20}, 32'h1, "async latency");
    $display("test pin done");
    wr(iqr_pkg::IDX_FLAGS_PIN, 8'h00);
    ext_pin <= 1'b0;
    wr(iqr_pkg::IDX_CORE_CTRL, 8'h41);
    sleep_req <= 1'b1;
    @(posedge core_clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk(iqr_pkg::IDX_STATUS, 8'h02, "status asleep");
    evt(4'h1);
    repeat (30) @(posedge core_clk);
    check({31'h0, core_asleep}, 32'h1, "no wake from clocked source");
    wr(iqr_pkg::IDX_FLAGS_CLK, 8'h00);
    nv = n_vec;
    ext_pin <= 1'b1;
    wait_cnt(n_wake, n_wake);
    repeat (25) @(posedge core_clk);
    check(n_vec, nv, "wake resumes without vector");
    check({31'h0, core_asleep}, 32'h0, "awake after pin");
    ext_pin <= 1'b0;
    wr(iqr_pkg::IDX_FLAGS_PIN, 8'h00);
    wr(iqr_pkg::IDX_CORE_CTRL, 8'hC1);
    sleep_req <= 1'b1;
    @(posedge core_clk);
    sleep_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    nv = n_vec;
    ext_pin <= 1'b1;
    wait_cnt(n_vec, nv);
    @(posedge core_clk);
    check(n_vec, nv + 1, "wake branches to vector");
    check({31'h0, vec_cyc - wake_cyc >= 4}, 32'h1, "one instruction before vector");
    $display("test sleep done");
    final_report();
  end
endmodule
`default_nettype wire

/* File: src/iqr_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module iqr_ctrl #(
  parameter int unsigned DISPATCH_Q1S = iqr_pkg::DISPATCH_Q1S
) (
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Avalon-MM slave.
  input  wire logic [13:0]   avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  // External interrupt pin.
  input  wire logic          ext_pin,
  // Peripheral events.
  input  wire logic          osc_fail_evt,
  input  wire logic          clk_switch_evt,
  input  wire logic          adc_thresh_evt,
  input  wire logic          adc_done_evt,
  input  wire logic [3:0]    capture_evt,
  // Core vectoring.
  input  wire logic          core_sleep_enter,
  output logic               core_irq_request,
  output logic               core_vector,
  output logic               core_wake,
  output logic               core_asleep
);

  if (DISPATCH_Q1S < 1 || DISPATCH_Q1S > 3) begin : g_chk
    $error("DISPATCH_Q1S must lie in 1..3");
  end

  iqr_timing_if tim ();

  iqr_phase_gen u_phase (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tim      (tim.phase_src)
  );

  iqr_pin_edge u_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ext_pin  (ext_pin),
    .tim      (tim.edge_src)
  );

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0]          ctrl_q;
  logic [7:0]          ctrl_d;
  logic                pin_flag_q;
  logic                pin_flag_d;
  logic                pin_en_q;
  logic [7:0]          clk_flags_q;
  logic [7:0]          clk_flags_d;
  logic [7:0]          clk_en_q;
  logic [7:0]          cap_flags_q;
  logic [7:0]          cap_flags_d;
  logic [7:0]          cap_en_q;
  logic                edge_pend_q;
  logic                sampled_q;
  logic [1:0]          disp_cnt_q;
  logic [1:0]          disp_cnt_d;
  iqr_pkg::iqr_state_t st_q;
  iqr_pkg::iqr_state_t st_d;
  logic                vector_d;
  logic                wake_d;
  logic                waitreq_q;
  logic [31:0]         rdata_q;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire        bus_req     = avs_read | avs_write;
  wire        bus_take    = bus_req & ~waitreq_q;
  wire        wr_ok       = bus_take & avs_write & avs_byteenable[0];
  wire [7:0]  wdat        = avs_writedata[7:0];
  wire        sel_ctrl    = (avs_address == {iqr_pkg::IDX_CORE_CTRL, 2'b00});
  wire        sel_fpin    = (avs_address == {iqr_pkg::IDX_FLAGS_PIN, 2'b00});
  wire        sel_fclk    = (avs_address == {iqr_pkg::IDX_FLAGS_CLK, 2'b00});
  wire        sel_fcap    = (avs_address == {iqr_pkg::IDX_FLAGS_CAP, 2'b00});
  wire        sel_epin    = (avs_address == {iqr_pkg::IDX_EN_BANK0, 2'b00});
  wire        sel_eclk    = (avs_address == {iqr_pkg::IDX_EN_CLK, 2'b00});
  wire        sel_ecap    = (avs_address == {iqr_pkg::IDX_EN_CAP, 2'b00});
  wire        sel_stat    = (avs_address == {iqr_pkg::IDX_STATUS, 2'b00});
  wire        we_ctrl     = wr_ok & sel_ctrl;
  wire        we_fpin     = wr_ok & sel_fpin;
  wire        we_fclk     = wr_ok & sel_fclk;
  wire        we_fcap     = wr_ok & sel_fcap;
  wire        we_epin     = wr_ok & sel_epin;
  wire        we_eclk     = wr_ok & sel_eclk;
  wire        we_ecap     = wr_ok & sel_ecap;

  // ****************************************************************
  // Flag setting; a hardware set always beats a software clear.
  // ****************************************************************
  wire        global_irq_enable       = ctrl_q[iqr_pkg::BIT_GLOBAL_EN];
  wire        peripheral_group_enable = ctrl_q[iqr_pkg::BIT_GROUP_EN];
  wire        q_window    = tim.q4 | tim.q1;
  wire        pin_set     = (edge_pend_q | tim.ext_edge) & q_window;  // [R3] [R4]
  wire [7:0]  clk_hw      = {osc_fail_evt, clk_switch_evt, 4'h0,
                             adc_thresh_evt, adc_done_evt};  // [R12] [R13] [R14]
  wire [7:0]  cap_hw      = {4'h0, capture_evt};

  assign tim.edge_rising = ctrl_q[iqr_pkg::BIT_EDGE];  // [R9]

  assign pin_flag_d  = pin_set | (we_fpin ? wdat[iqr_pkg::BIT_PIN] : pin_flag_q);  // [R15]
  assign clk_flags_d = (clk_hw & iqr_pkg::CLK_MASK) |
                       (we_fclk ? (wdat & iqr_pkg::CLK_MASK) : clk_flags_q);  // [R12] [R13] [R14] [R15]
  assign cap_flags_d = (cap_hw & iqr_pkg::CAP_MASK) |
                       (we_fcap ? (wdat & iqr_pkg::CAP_MASK) : cap_flags_q);  // [R15]

  // ****************************************************************
  // Request forming and wake qualification.
  // ****************************************************************
  wire        pin_term    = pin_flag_q & pin_en_q;  // [R8]
  wire        per_term    = (|(clk_flags_q & clk_en_q)) | (|(cap_flags_q & cap_en_q));
  wire        any_term    = pin_term | (peripheral_group_enable & per_term);  // [R11] [R16]
  wire        irq_now     = global_irq_enable & any_term;  // [R16]
  // Only the pin and the fail-safe monitor keep running without the
  // system clock, so only they may end Sleep.
  wire        osc_term    = clk_flags_q[iqr_pkg::BIT_OSC_FAIL] & clk_en_q[iqr_pkg::BIT_OSC_FAIL];
  wire        wake_any    = pin_term | (peripheral_group_enable & osc_term);  // [R5]
  wire        disp_last   = (disp_cnt_q == 2'(DISPATCH_Q1S - 1));

  // Hardware drops the global enable as it vectors so the handler is not
  // re-entered; a software write in the same cycle still wins.
  always_comb begin
    ctrl_d = ctrl_q;
    if (we_ctrl) begin
      ctrl_d = wdat & iqr_pkg::CTRL_MASK;
    end else if (vector_d) begin
      ctrl_d[iqr_pkg::BIT_GLOBAL_EN] = 1'b0;
    end
  end

  // ****************************************************************
  // Dispatch and sleep sequencing, counted in instruction cycles.
  // ****************************************************************
  always_comb begin
    st_d       = st_q;
    disp_cnt_d = disp_cnt_q;
    vector_d   = 1'b0;
    wake_d     = 1'b0;
    unique case (st_q)
      iqr_pkg::ST_RUN: begin
        if (core_sleep_enter) begin
          st_d = iqr_pkg::ST_SLEEP;
        end else if (tim.q1 && irq_now) begin  // [R2]
          st_d       = iqr_pkg::ST_DISPATCH;
          disp_cnt_d = 2'h0;
        end
      end
      iqr_pkg::ST_DISPATCH: begin
        // Counting Q1 strobes keeps the delay blind to instruction length.
        if (tim.q1) begin  // [R1]
          if (disp_last) begin
            vector_d = 1'b1;
            st_d     = iqr_pkg::ST_RUN;
          end else begin
            disp_cnt_d = disp_cnt_q + 2'h1;
          end
        end
      end
      iqr_pkg::ST_SLEEP: begin
        if (wake_any) begin  // [R5]
          wake_d = 1'b1;
          st_d   = iqr_pkg::ST_WAKE;
        end
      end
      iqr_pkg::ST_WAKE: begin
        // The next Q1 starts the instruction after the sleep; dispatch
        // then runs for whole cycles, so that instruction completes.
        if (tim.q1) begin  // [R7]
          if (irq_now) begin  // [R6]
            st_d       = iqr_pkg::ST_DISPATCH;
            disp_cnt_d = 2'h0;
          end else begin
            st_d = iqr_pkg::ST_RUN;  // [R6]
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Read data selection.
  // ****************************************************************
  wire [7:0]  stat_byte   = {5'h00, (st_q == iqr_pkg::ST_DISPATCH), core_asleep, irq_now};
  wire [7:0]  rd_byte     = sel_ctrl ? ctrl_q :
                            sel_fpin ? {3'h0, pin_flag_q, 4'h0} :
                            sel_fclk ? clk_flags_q :
                            sel_fcap ? cap_flags_q :
                            sel_epin ? {3'h0, pin_en_q, 4'h0} :
                            sel_eclk ? clk_en_q :
                            sel_ecap ? cap_en_q :  // [R10]
                            sel_stat ? stat_byte : 8'h00;

  // ****************************************************************
  // Bus handshake: one wait cycle, then the access edge.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else begin
      waitreq_q <= ~(bus_req & waitreq_q);
      if (bus_req && waitreq_q) begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign avs_waitrequest = waitreq_q;
  assign avs_readdata    = rdata_q;

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= iqr_pkg::CTRL_RST;
      pin_flag_q  <= 1'b0;
      clk_flags_q <= iqr_pkg::FLAGS_RST;
      cap_flags_q <= iqr_pkg::FLAGS_RST;
    end else begin
      ctrl_q      <= ctrl_d;
      pin_flag_q  <= pin_flag_d;
      clk_flags_q <= clk_flags_d;
      cap_flags_q <= cap_flags_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_en_q <= 1'b0;
      clk_en_q <= iqr_pkg::EN_RST;
      cap_en_q <= iqr_pkg::EN_RST;  // [R10]
    end else begin
      if (we_epin) begin
        pin_en_q <= wdat[iqr_pkg::BIT_PIN];  // [R8]
      end
      if (we_eclk) begin
        clk_en_q <= wdat & iqr_pkg::CLK_MASK;
      end
      if (we_ecap) begin
        cap_en_q <= wdat & iqr_pkg::CAP_MASK;  // [R10]
      end
    end
  end

  // An edge seen in Q2 or Q3 waits here for the Q4-Q1 window.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_pend_q <= 1'b0;
    end else begin
      edge_pend_q <= (edge_pend_q | tim.ext_edge) & ~q_window;  // [R3]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled_q <= 1'b0;
    end else if (tim.q1) begin
      sampled_q <= pin_flag_q;  // [R2]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q             <= iqr_pkg::ST_RUN;
      disp_cnt_q       <= 2'h0;
      core_irq_request <= 1'b0;
      core_vector      <= 1'b0;
      core_wake        <= 1'b0;
      core_asleep      <= 1'b0;
    end else begin
      st_q             <= st_d;
      disp_cnt_q       <= disp_cnt_d;
      core_irq_request <= irq_now;  // [R16]
      core_vector      <= vector_d;  // [R1]
      core_wake        <= wake_d;  // [R5]
      core_asleep      <= (st_d == iqr_pkg::ST_SLEEP);
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_r1_latency;
    (st_q == iqr_pkg::ST_RUN && tim.q1 && irq_now && !core_sleep_enter)
      |-> ##[12:14] core_vector;
  endproperty
  a_r1_latency: assert property (p_r1_latency) else $error("vector late or missing");  // [R1]

  property p_r2_sample;
    !$stable(sampled_q) |-> $past(tim.q1);
  endproperty
  a_r2_sample: assert property (p_r2_sample) else $error("pin flag sampled outside Q1");  // [R2]

  property p_r3_window;
    ($rose(pin_flag_q) && !$past(we_fpin)) |-> $past(q_window);
  endproperty
  a_r3_window: assert property (p_r3_window) else $error("pin flag set outside Q4-Q1");  // [R3]

  property p_r7_wake_first;
    $rose(core_wake) |-> !core_vector [*8];
  endproperty
  a_r7_wake_first: assert property (p_r7_wake_first) else $error("vector before post-sleep instr");  // [R7]

  property p_r6_resume;
    (st_q == iqr_pkg::ST_WAKE && tim.q1 && !global_irq_enable) |=> (st_q == iqr_pkg::ST_RUN);
  endproperty
  a_r6_resume: assert property (p_r6_resume) else $error("vectored without global enable");  // [R6]

  property p_r11_group;
    (!peripheral_group_enable && !pin_term) |=> !core_irq_request;
  endproperty
  a_r11_group: assert property (p_r11_group) else $error("peripheral bypassed group enable");  // [R11]

  property p_r16_global;
    core_irq_request |-> $past(global_irq_enable) && $past(any_term);
  endproperty
  a_r16_global: assert property (p_r16_global) else $error("request without enables");  // [R16]

  property p_r12_osc;
    osc_fail_evt |=> clk_flags_q[7] [*2];
  endproperty
  a_r12_osc: assert property (p_r12_osc) else $error("oscillator fail flag not held");  // [R12]

  property p_r14_adc;
    adc_done_evt |=> clk_flags_q[0];
  endproperty
  a_r14_adc: assert property (p_r14_adc) else $error("ADC done flag not set");  // [R14]

  property p_r15_cap;
    (capture_evt[0] && !cap_en_q[0]) |=> cap_flags_q[0];
  endproperty
  a_r15_cap: assert property (p_r15_cap) else $error("flag gated by its enable");  // [R15]

  property p_r10_cap_en;
    (wr_ok && sel_ecap) |=> (cap_en_q == ($past(avs_writedata[7:0]) & 8'h0F));
  endproperty
  a_r10_cap_en: assert property (p_r10_cap_en) else $error("capture enable write wrong");  // [R10]

  c_vector: cover property (core_vector);
  c_wake: cover property (core_wake ##[1:20] core_vector);
  c_pin: cover property ($rose(pin_flag_q));
  c_resume: cover property (st_q == iqr_pkg::ST_WAKE ##1 st_q == iqr_pkg::ST_RUN);

endmodule
`default_nettype wire

/* File: src/iqr_phase_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module iqr_phase_gen (
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Quarter phase strobes.
  iqr_timing_if.phase_src    tim
);

  logic [1:0] quarter_q;

  // ****************************************************************
  // Quarter counter; Q1 is quarter zero, Q4 is quarter three.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quarter_q <= 2'h0;
    end else begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  assign tim.q1 = (quarter_q == 2'h0);
  assign tim.q4 = (quarter_q == 2'h3);

endmodule
`default_nettype wire

/* File: src/iqr_pin_edge.sv */
`timescale 1ns/10ps
`default_nettype none
module iqr_pin_edge (
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Asynchronous pin.
  input  wire logic          ext_pin,
  // Edge pulse towards the controller.
  iqr_timing_if.edge_src     tim
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // ****************************************************************
  // Two-stage synchroniser, then a history stage for the edge.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= ext_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign tim.ext_edge = (sync2_q ^ prev_q) & (sync2_q == tim.edge_rising);  // [R8] [R9]

  property p_r9_edge_dir;
    @(posedge core_clk) disable iff (!rst_n)
      (tim.ext_edge && $stable(tim.edge_rising)) |=> (prev_q == $past(tim.edge_rising));
  endproperty
  a_r9_edge_dir: assert property (p_r9_edge_dir) else $error("edge against selected direction");  // [R9]

endmodule
`default_nettype wire

/* File: src/iqr_pkg.sv */
// Function
// (R1) Vector 3-5 cycles async, 3-4 sync
// (R2) Sample pin flag once, at Q1
// (R3) Pin flag set only in Q4-Q1
// (R4) Arrival within window varies observed latency
// (R5) Only clockless enabled sources wake Sleep
// (R6) Wake vectors if global enable, else resumes
// (R7) One instruction after sleep runs before vector
// (R8) Pin interrupt edge triggered, gated by enable
// (R9) Edge select: one rising, zero falling
// (R10) Capture enables bits 3-0, reset zero
// (R11) Peripheral terms need peripheral group enable
// (R12) Oscillator fail sets bit 7, sticky
// (R13) Clock switch ready sets bit 6
// (R14) ADC completion sets bits 1 and 0; the code sets bit 0 on ADC done and bit 1 on ADC threshold
// (R15) Flags set regardless of any enable
// (R16) One request: flags and enables, gated globally
// (R17) Software clears flag before enabling source
package iqr_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [11:0] IDX_CORE_CTRL  = 12'h030B;
  localparam logic [11:0] IDX_FLAGS_PIN  = 12'h070C;
  localparam logic [11:0] IDX_FLAGS_CLK  = 12'h070D;
  localparam logic [11:0] IDX_FLAGS_CAP  = 12'h0712;
  localparam logic [11:0] IDX_EN_BANK0   = 12'h0716;
  localparam logic [11:0] IDX_EN_CLK     = 12'h0717;
  localparam logic [11:0] IDX_EN_CAP     = 12'h071C;
  localparam logic [11:0] IDX_STATUS     = 12'h07F0;

  // ****************************************************************
  // Field positions, masks and reset values.
  // ****************************************************************
  localparam int unsigned BIT_GLOBAL_EN  = 7;
  localparam int unsigned BIT_GROUP_EN   = 6;
  localparam int unsigned BIT_EDGE       = 0;
  localparam int unsigned BIT_PIN        = 4;
  localparam int unsigned BIT_OSC_FAIL   = 7;
  localparam logic [7:0]  CTRL_MASK      = 8'hC1;
  localparam logic [7:0]  CLK_MASK       = 8'hC3;
  localparam logic [7:0]  CAP_MASK       = 8'h0F;
  localparam logic [7:0]  PIN_MASK       = 8'h10;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  FLAGS_RST      = 8'h00;
  localparam logic [7:0]  EN_RST         = 8'h00;

  // ****************************************************************
  // Timing: four quarter phases per instruction cycle.
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned QUARTERS       = 4;
  localparam int unsigned TCY_NS         = QUARTERS * CLK_PERIOD_NS;
  localparam int unsigned DISPATCH_Q1S   = 3;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DISPATCH,
    ST_SLEEP,
    ST_WAKE
  } iqr_state_t;

endpackage

/* File: src/iqr_timing_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface iqr_timing_if;
  logic q1;
  logic q4;
  logic ext_edge;
  logic edge_rising;

  modport phase_src (output q1, output q4);
  modport edge_src  (output ext_edge, input edge_rising);
  modport sink      (input q1, input q4, input ext_edge, output edge_rising);
endinterface
`default_nettype wire
